/* common/ufr_params.svh */
/*
 * Register offsets, field positions and reset values of the USB flag
 * router block. Definitions only; include once per compilation unit.
 */
`ifndef UFR_PARAMS_SVH
`define UFR_PARAMS_SVH

`define UFR_OFS_EVENT_FLAGS 8'h1c
`define UFR_OFS_STICKY_MASK 8'h20
`define UFR_OFS_PORT_MASKS 8'h24
`define UFR_OFS_SOF_COUNT 8'h28
`define UFR_OFS_PACKET_ID 8'h2c
`define UFR_OFS_ENDPOINT 8'h30
`define UFR_OFS_EP_TAG_MASK 8'h34
`define UFR_OFS_OTG_MASK 8'h38
`define UFR_OFS_POWER_SIG 8'h3c
`define UFR_OFS_IRQ_STATUS 8'h40
`define UFR_OFS_IRQ_MASK 8'h44

`define UFR_FLAG_W 7
`define UFR_FLAG_TOKEN 6
`define UFR_FLAG_SE0 5
`define UFR_FLAG_K 4
`define UFR_FLAG_J 3
`define UFR_FLAG_CRC16 2
`define UFR_FLAG_RXACTIVE 1
`define UFR_FLAG_RXERROR 0
`define UFR_FLAG_LEVEL_BITS 7'h03

`define UFR_SOF_W 11
`define UFR_EP_VALID_BIT 4
`define UFR_EP_TAG 5'h10
`define UFR_PWR_VALID_BIT 8

`define UFR_IRQ_W 4
`define UFR_IRQ_TOKEN 0
`define UFR_IRQ_CRC16 1
`define UFR_IRQ_SOF 2
`define UFR_IRQ_PKT 3

`define UFR_RESET_WORD 32'h0000_0000

`endif

/* common/ufr_pkg.sv */
/*
 * Types and shared helpers of the USB flag router block.
 * Assumes ufr_params.svh is on the include path.
 */
`include "ufr_params.svh"

package ufr_pkg;

  typedef logic [`UFR_FLAG_W-1:0] ufr_flags_type;

  // Line state coding of the transceiver
  typedef enum logic [1:0] {
    UFR_LS_SE0 = 2'h0,
    UFR_LS_J = 2'h1,
    UFR_LS_K = 2'h2,
    UFR_LS_SE1 = 2'h3
  } ufr_linestate_type;

  // High when any flag picked by the mask is high
  function automatic logic ufr_any_masked(input logic [7:0] mask,
                                          input ufr_flags_type flags);
    ufr_any_masked = |(mask[`UFR_FLAG_W-1:0] & flags);
  endfunction

endpackage

/* common/ufr_reg_if.sv */
/*
 * Register access carrier between the bus slave and the register file.
 * Assumes both ends share hclk; strobes are one-cycle pulses.
 */
`timescale 1ns/10ps

interface ufr_reg_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport bus_side (
    output wr_en,
    output rd_en,
    output addr,
    output wdata,
    input rdata
  );

  modport reg_side (
    input wr_en,
    input rd_en,
    input addr,
    input wdata,
    output rdata
  );
endinterface

/* verilog/ufr_ahb_slave.sv */
/*
 * AHB-Lite slave front end: writes complete with no wait state, reads
 * take one wait state so that read data come from a register.
 * Assumes single word transfers and that hready is this slave's hreadyout.
 */
`timescale 1ns/10ps

module ufr_ahb_slave (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  ufr_reg_if.bus_side regs
);

  logic dp_valid_r;
  logic dp_write_r;
  logic [7:0] dp_addr_r;
  logic rd_wait_r;
  logic [31:0] hrdata_r;
  logic take;
  logic unused_ok;

  // Size is not checked: only whole-word transfers are issued
  assign unused_ok = ^{hsize, haddr[31:8], haddr[1:0]};
  assign take = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else if (hready) begin
      dp_valid_r <= take;
      dp_write_r <= hwrite;
      dp_addr_r <= {haddr[7:2], 2'h0};
    end
  end

  // The wait state lets a write just ahead of a read land first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait_r <= 1'b0;
    end else begin
      rd_wait_r <= take & ~hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_wait_r) begin
      hrdata_r <= regs.rdata;
    end
  end

  assign hreadyout = ~rd_wait_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign regs.addr = dp_addr_r;
  assign regs.wdata = hwdata;
  assign regs.wr_en = dp_valid_r & dp_write_r & hready;
  assign regs.rd_en = rd_wait_r;

endmodule

/* verilog/ufr_flag_engine.sv */
/*
 * Event flag store with per-bit stickiness and write-one-to-clear.
 * Assumes raise inputs are already formed for this cycle.
 */
`timescale 1ns/10ps

`include "ufr_params.svh"

module ufr_flag_engine (
  input wire logic hclk,
  input wire logic hresetn,
  input wire ufr_pkg::ufr_flags_type raise,
  input wire ufr_pkg::ufr_flags_type sticky,
  input wire ufr_pkg::ufr_flags_type sw_clear,
  input wire logic pkt_start,
  output ufr_pkg::ufr_flags_type flags
);

  ufr_pkg::ufr_flags_type flags_r;
  ufr_pkg::ufr_flags_type flags_nxt;
  ufr_pkg::ufr_flags_type keep;
  ufr_pkg::ufr_flags_type level_bits;

  assign level_bits = `UFR_FLAG_LEVEL_BITS;
  // Sticky bits hold; level bits follow; others drop at packet start
  assign keep = sticky | (~level_bits & {`UFR_FLAG_W{~pkt_start}});
  // Raise wins over a clear in the same cycle
  assign flags_nxt = raise | (flags_r & keep & ~sw_clear);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

endmodule

/* verilog/ufr_top.sv */
/*
 * Register-controlled part of a USB interface machine: event flags routed
 * onto three processor port bits, start-of-frame count, last packet id and
 * endpoint capture, endpoint tagging on the receive port, OTG mask and
 * power-signalling words, and a read-to-clear interrupt.
 * Assumes receive-side inputs are synchronous to hclk; strobes are
 * one-cycle pulses.
 */
`timescale 1ns/10ps

`include "ufr_params.svh"

// Summary of operation
// - First port is OR of flags masked by bits 7:0
// - Second port ORs flags masked by bits 15:8
// - Third port ORs flags masked by bits 23:16
// - Eleven-bit frame counter, software readable and writable
// - Capture each received packet id, read-only
// - Store last token endpoint number, read-only
// - Endpoint valid bit set once endpoint stored
// - Tagged endpoints leave receive port ORed with 0x10
// - Thirty-two bit OTG mask word, read-write
// - Power word: valid bit 8, data 7:0
// - Seven event flags from token, line, CRC, receive
// - Non-sticky flags clear when next packet begins, except receive active and error, which follow their inputs
// - Sticky flags hold until software writes one
module ufr_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic pkt_start,
  input wire logic token_ok,
  input wire logic crc16_fail,
  input wire logic [1:0] line_state,
  input wire logic rx_active,
  input wire logic rx_error,
  input wire logic pid_valid,
  input wire logic [3:0] pid,
  input wire logic ep_valid,
  input wire logic [3:0] ep,
  input wire logic sof_valid,
  input wire logic [10:0] sof_frame,
  output logic flag_port_first,
  output logic flag_port_second,
  output logic flag_port_third,
  output logic [4:0] rx_ep_out,
  output logic rx_ep_strobe,
  output logic irq
);

  ufr_reg_if regs ();

  logic [31:0] port_masks_r;
  ufr_pkg::ufr_flags_type sticky_r;
  logic [`UFR_SOF_W-1:0] sof_r;
  logic [3:0] pid_r;
  logic [3:0] ep_r;
  logic ep_ok_r;
  logic [15:0] ep_tag_mask_r;
  logic [31:0] otg_mask_r;
  logic [8:0] power_r;
  logic [`UFR_IRQ_W-1:0] irq_status_r;
  logic [`UFR_IRQ_W-1:0] irq_mask_r;
  logic [4:0] rx_ep_out_r;
  logic rx_ep_strobe_r;

  ufr_pkg::ufr_flags_type event_flag_vector;
  ufr_pkg::ufr_flags_type raise;
  ufr_pkg::ufr_flags_type sw_clear;
  ufr_pkg::ufr_linestate_type ls;
  logic [`UFR_IRQ_W-1:0] irq_events;
  logic [`UFR_IRQ_W-1:0] irq_status_nxt;
  logic [31:0] rdata_mux;

  logic wr_flags;
  logic wr_sticky;
  logic wr_pmask;
  logic wr_sof;
  logic wr_tag;
  logic wr_otg;
  logic wr_power;
  logic wr_imask;
  logic rd_istatus;

  ufr_ahb_slave u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .regs(regs)
  );

  // Write and read decode; unmapped addresses fall through
  assign wr_flags = regs.wr_en & (regs.addr == `UFR_OFS_EVENT_FLAGS);
  assign wr_sticky = regs.wr_en & (regs.addr == `UFR_OFS_STICKY_MASK);
  assign wr_pmask = regs.wr_en & (regs.addr == `UFR_OFS_PORT_MASKS);
  assign wr_sof = regs.wr_en & (regs.addr == `UFR_OFS_SOF_COUNT);
  assign wr_tag = regs.wr_en & (regs.addr == `UFR_OFS_EP_TAG_MASK);
  assign wr_otg = regs.wr_en & (regs.addr == `UFR_OFS_OTG_MASK);
  assign wr_power = regs.wr_en & (regs.addr == `UFR_OFS_POWER_SIG);
  assign wr_imask = regs.wr_en & (regs.addr == `UFR_OFS_IRQ_MASK);
  assign rd_istatus = regs.rd_en & (regs.addr == `UFR_OFS_IRQ_STATUS);

  // Event flag sources
  assign ls = ufr_pkg::ufr_linestate_type'(line_state);
  always_comb begin
    raise = '0;
    raise[`UFR_FLAG_TOKEN] = token_ok;
    raise[`UFR_FLAG_SE0] = (ls == ufr_pkg::UFR_LS_SE0);
    raise[`UFR_FLAG_K] = (ls == ufr_pkg::UFR_LS_K);
    raise[`UFR_FLAG_J] = (ls == ufr_pkg::UFR_LS_J);
    raise[`UFR_FLAG_CRC16] = crc16_fail;
    raise[`UFR_FLAG_RXACTIVE] = rx_active;
    raise[`UFR_FLAG_RXERROR] = rx_error;
  end

  assign sw_clear = wr_flags ? regs.wdata[`UFR_FLAG_W-1:0] : '0;

  ufr_flag_engine u_flags (
    .hclk(hclk),
    .hresetn(hresetn),
    .raise(raise),
    .sticky(sticky_r),
    .sw_clear(sw_clear),
    .pkt_start(pkt_start),
    .flags(event_flag_vector)
  );

  // Port outputs follow the flag store with no extra delay
  assign flag_port_first =
    ufr_pkg::ufr_any_masked(port_masks_r[7:0], event_flag_vector);
  assign flag_port_second =
    ufr_pkg::ufr_any_masked(port_masks_r[15:8], event_flag_vector);
  assign flag_port_third =
    ufr_pkg::ufr_any_masked(port_masks_r[23:16], event_flag_vector);

  // Software configuration words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_masks_r <= `UFR_RESET_WORD;
    end else if (wr_pmask) begin
      port_masks_r <= regs.wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sticky_r <= '0;
    end else if (wr_sticky) begin
      sticky_r <= regs.wdata[`UFR_FLAG_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ep_tag_mask_r <= 16'h0000;
    end else if (wr_tag) begin
      ep_tag_mask_r <= regs.wdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      otg_mask_r <= `UFR_RESET_WORD;
    end else if (wr_otg) begin
      otg_mask_r <= regs.wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_r <= 9'h000;
    end else if (wr_power) begin
      power_r <= regs.wdata[`UFR_PWR_VALID_BIT:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_r <= '0;
    end else if (wr_imask) begin
      irq_mask_r <= regs.wdata[`UFR_IRQ_W-1:0];
    end
  end

  // A received frame number beats a software write in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sof_r <= '0;
    end else if (sof_valid) begin
      sof_r <= sof_frame;
    end else if (wr_sof) begin
      sof_r <= regs.wdata[`UFR_SOF_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pid_r <= 4'h0;
    end else if (pid_valid) begin
      pid_r <= pid;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ep_r <= 4'h0;
      ep_ok_r <= 1'b0;
    end else if (ep_valid) begin
      ep_r <= ep;
      ep_ok_r <= 1'b1;
    end
  end

  // Receive port: endpoint leaves tagged when its match bit is set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_ep_out_r <= 5'h00;
      rx_ep_strobe_r <= 1'b0;
    end else begin
      rx_ep_strobe_r <= ep_valid;
      if (ep_valid) begin
        rx_ep_out_r <= {1'b0, ep} |
          (ep_tag_mask_r[ep] ? `UFR_EP_TAG : 5'h00);
      end
    end
  end

  assign rx_ep_out = rx_ep_out_r;
  assign rx_ep_strobe = rx_ep_strobe_r;

  // Interrupt status: new events beat the clear-on-read
  assign irq_events[`UFR_IRQ_TOKEN] = token_ok;
  assign irq_events[`UFR_IRQ_CRC16] = crc16_fail;
  assign irq_events[`UFR_IRQ_SOF] = sof_valid;
  assign irq_events[`UFR_IRQ_PKT] = pkt_start;
  assign irq_status_nxt = irq_events |
    (irq_status_r & {`UFR_IRQ_W{~rd_istatus}});

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  assign irq = |(irq_status_r & irq_mask_r);

  // Read mux; reserved bits and unmapped addresses read zero
  always_comb begin
    rdata_mux = 32'h0000_0000;
    unique case (regs.addr)
      `UFR_OFS_EVENT_FLAGS: rdata_mux[`UFR_FLAG_W-1:0] = event_flag_vector;
      `UFR_OFS_STICKY_MASK: rdata_mux[`UFR_FLAG_W-1:0] = sticky_r;
      `UFR_OFS_PORT_MASKS: rdata_mux = port_masks_r;
      `UFR_OFS_SOF_COUNT: rdata_mux[`UFR_SOF_W-1:0] = sof_r;
      `UFR_OFS_PACKET_ID: rdata_mux[3:0] = pid_r;
      `UFR_OFS_ENDPOINT: rdata_mux[`UFR_EP_VALID_BIT:0] = {ep_ok_r, ep_r};
      `UFR_OFS_EP_TAG_MASK: rdata_mux[15:0] = ep_tag_mask_r;
      `UFR_OFS_OTG_MASK: rdata_mux = otg_mask_r;
      `UFR_OFS_POWER_SIG: rdata_mux[`UFR_PWR_VALID_BIT:0] = power_r;
      `UFR_OFS_IRQ_STATUS: rdata_mux[`UFR_IRQ_W-1:0] = irq_status_r;
      `UFR_OFS_IRQ_MASK: rdata_mux[`UFR_IRQ_W-1:0] = irq_mask_r;
      default: rdata_mux = 32'h0000_0000;
    endcase
  end

  assign regs.rdata = rdata_mux;

endmodule

/* verification/ufr_top_sva.sv */
/*
 * Checker for ufr_top: bus wait states, read data holding and the
 * receive-port endpoint strobe. Sees only the top module's ports and
 * is bound to it at the foot of this file.
 */
`timescale 1ns/10ps

module ufr_top_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic ep_valid,
  input wire logic [3:0] ep,
  input wire logic [4:0] rx_ep_out,
  input wire logic rx_ep_strobe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  wire logic taken = hsel && htrans[1] && hready;

  sequence read_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  chk_read_wait: assert property (taken && !hwrite |=> read_wait)
    else $error("read data phase not exactly one wait state");
  chk_write_fast: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  chk_stall_cause: assert property (!hreadyout |-> $past(taken && !hwrite))
    else $error("wait state without a read");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response other than okay");
  chk_rdata_hold: assert property (!$stable(hrdata) |-> $past(!hreadyout))
    else $error("read data changed outside a read");
  chk_ep_strobe: assert property (ep_valid |=> rx_ep_strobe)
    else $error("no receive strobe after endpoint");
  chk_strobe_cause: assert property (rx_ep_strobe |-> $past(ep_valid))
    else $error("receive strobe without endpoint");
  chk_ep_value: assert property (ep_valid |=> rx_ep_out[3:0] == $past(ep))
    else $error("receive port endpoint wrong");
  chk_ep_hold: assert property (!ep_valid |=> $stable(rx_ep_out))
    else $error("receive port changed without endpoint");
endmodule

bind ufr_top ufr_top_sva ufr_top_sva_inst (.hclk, .hresetn, .hsel,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .ep_valid, .ep,
  .rx_ep_out, .rx_ep_strobe);

/* verification/ufr_rx_model.sv */
/*
 * Receive-side partner: transceiver line state, levels and one-cycle
 * packet event pulses. Driven by bench calls; changes just after edges.
 */
`timescale 1ns/10ps

module ufr_rx_model (
  input wire logic hclk,
  output logic pkt_start,
  output logic token_ok,
  output logic crc16_fail,
  output logic [1:0] line_state,
  output logic rx_active,
  output logic rx_error,
  output logic pid_valid,
  output logic [3:0] pid,
  output logic ep_valid,
  output logic [3:0] ep,
  output logic sof_valid,
  output logic [10:0] sof_frame
);
  initial begin
    {pkt_start, token_ok, crc16_fail, pid_valid, ep_valid, sof_valid} = '0;
    line_state = 2'h3;
    {rx_active, rx_error} = 2'h0;
    {pid, ep, sof_frame} = '0;
  end

  // p = {pkt, token, crc, pid, ep, sof}; returns at the taking edge
  task automatic ev(input logic [5:0] p, input logic [3:0] v,
                    input logic [10:0] f);
    @(posedge hclk);
    {pkt_start, token_ok, crc16_fail, pid_valid, ep_valid, sof_valid} <= p;
    {pid, ep, sof_frame} <= {v, v, f};
    @(posedge hclk);
    {pkt_start, token_ok, crc16_fail, pid_valid, ep_valid, sof_valid} <= '0;
    // Data no longer qualified: show the inverse, never a held value
    {pid, ep, sof_frame} <= ~{v, v, f};
  endtask

  task automatic lvl(input logic [1:0] ls, input logic act,
                     input logic err);
    @(posedge hclk);
    {line_state, rx_active, rx_error} <= {ls, act, err};
    @(posedge hclk);
  endtask
endmodule

/* verification/tb_top.sv */
/*
 * Self-checking bench for ufr_top: registers over AHB-Lite, flag routing
 * to the three ports, stickiness, capture, tagging and the interrupt.
 * Assumes the receive side comes from ufr_rx_model.
 */
`timescale 1ns/10ps

module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire logic hreadyout, hresp, p1, p2, p3, irq, rx_ep_strobe;
  wire logic [31:0] hrdata;
  wire logic pkt_start, token_ok, crc16_fail, rx_active, rx_error;
  wire logic pid_valid, ep_valid, sof_valid;
  wire logic [1:0] line_state;
  wire logic [3:0] pid, ep;
  wire logic [10:0] sof_frame;
  wire logic [4:0] rx_ep_out;
  int fail_count = 0;
  int total_checks = 0;
  logic [31:0] q;
  logic [31:0] rw_exp [7] = '{32'hffff_ffff, 32'h0000_07ff, 32'h0, 32'h0,
                               32'h0000_ffff, 32'hffff_ffff, 32'h0000_01ff};
  logic [7:0] ls_exp [4] = '{8'h20, 8'h08, 8'h10, 8'h01};
  logic [3:0] ep_list [3] = '{4'h3, 4'h5, 4'hf};

  always #4 hclk = ~hclk;

  ufr_rx_model ufr_rx_model_inst (.hclk, .pkt_start, .token_ok, .crc16_fail,
    .line_state, .rx_active, .rx_error, .pid_valid, .pid, .ep_valid, .ep,
    .sof_valid, .sof_frame);

  ufr_top ufr_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .pkt_start, .token_ok, .crc16_fail, .line_state, .rx_active, .rx_error,
    .pid_valid, .pid, .ep_valid, .ep, .sof_valid, .sof_frame,
    .flag_port_first(p1), .flag_port_second(p2), .flag_port_third(p3),
    .rx_ep_out, .rx_ep_strobe, .irq);

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Samples ready mid-cycle, then returns at the edge that takes it
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      q = hrdata;
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    // Only a wait that never saw ready counts as a hang
    if (hreadyout !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end
    @(posedge hclk);
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic ev(input logic [5:0] p, input logic [3:0] v);
    ufr_rx_model_inst.ev(p, v, 11'h5a5);
  endtask

  task automatic lvl(input logic [1:0] ls, input logic a, input logic e);
    ufr_rx_model_inst.lvl(ls, a, e);
  endtask

  task automatic ports(input logic [2:0] e);
    @(negedge hclk);
    chk({29'h0, p3, p2, p1}, {29'h0, e});
    @(posedge hclk);
  endtask

  task automatic irq_is(input logic e);
    @(negedge hclk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge hclk);
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(8'h24 + 8'(4 * i), 32'h0);
    end
    for (int i = 0; i < 7; i++) begin
      wr(8'h24 + 8'(4 * i), 32'hffff_ffff);
      rd(8'h24 + 8'(4 * i), rw_exp[i]);
    end
    rd(8'h50, 32'h0);
    wr(8'h24, 32'h0004_0240);
    wr(8'h20, 32'h0);
    lvl(2'h3, 1'b1, 1'b0);
    ports(3'h2);
    ev(6'h10, 4'h0);
    ports(3'h3);
    ev(6'h20, 4'h0);
    ports(3'h2);
    ev(6'h08, 4'h0);
    ports(3'h6);
    lvl(2'h3, 1'b0, 1'b0);
    ports(3'h4);
    ev(6'h20, 4'h0);
    ports(3'h0);
    wr(8'h20, 32'h44);
    ev(6'h18, 4'h0);
    ev(6'h20, 4'h0);
    ports(3'h5);
    rd(8'h1c, 32'h44);
    wr(8'h1c, 32'h40);
    ports(3'h4);
    wr(8'h1c, 32'h04);
    ports(3'h0);
    wr(8'h20, 32'h0);
    for (int i = 0; i < 4; i++) begin
      lvl(2'(i), 1'b0, i == 3);
      lvl(2'h3, 1'b0, i == 3);
      rd(8'h1c, {24'h0, ls_exp[i]});
      ev(6'h20, 4'h0);
    end
    lvl(2'h3, 1'b0, 1'b0);
    wr(8'h34, 32'h0000_8008);
    for (int i = 0; i < 3; i++) begin
      ev(6'h06, ep_list[i]);
      @(negedge hclk);
      chk({26'h0, rx_ep_strobe, rx_ep_out},
          {26'h0, 1'b1, ep_list[i] != 4'h5, ep_list[i]});
      @(posedge hclk);
      rd(8'h30, {28'h1, ep_list[i]});
      rd(8'h2c, {28'h0, ep_list[i]});
    end
    ev(6'h01, 4'h0);
    rd(8'h28, 32'h0000_05a5);
    rd(8'h40, 32'h0000_000f);
    wr(8'h44, 32'h1);
    ev(6'h08, 4'h0);
    irq_is(1'b0);
    ev(6'h10, 4'h0);
    irq_is(1'b1);
    rd(8'h40, 32'h0000_0003);
    irq_is(1'b0);
    wr(8'h24, 32'hff00_0000);
    lvl(2'h0, 1'b1, 1'b1);
    ports(3'h0);
    // Mid-run reset after registers and outputs hold non-zero values
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk(hrdata, 32'h0);
    chk({26'h0, rx_ep_strobe, rx_ep_out}, 32'h0);
    @(posedge hclk);
    rd(8'h24, 32'h0);
    rd(8'h30, 32'h0);
    rd(8'h34, 32'h0);
    rd(8'h38, 32'h0);
    tally_and_finish();
  end
endmodule
